//--- oled_gray_pwm_row_scan.sv
// Column pulse-width timing and row scan sequencing with an AHB-Lite register slave
`include "oled_timing_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - 64-level gray uses fixed internal pulse table
// - Values 0-15 direct; 16-31 doubled steps to 46
// - 32-47 step 4; 48-59 step 8; then 208..256
// - Gray modes: odd and even columns share table
// - Monochrome off pixel never sources current
// - Monochrome on: odd/even byte by colour pin
// - Selected row grounded, others released high
// - Vertical flip inverts row to memory line order
// - Scan field binary 10 selects single scanning
// - Single scan ascending from first row to 72
// - Reverse bit scans descending from row 72
// - Scan field binary 11 selects dual scanning
// - Dual scan: odd/even pair, 36 periods
// - Reverse bit orders pairs as in single
// - Drive period lasts 256 step clock cycles
// - After count elapses column held at ground
module oled_gray_pwm_row_scan #(
    parameter int ROWS     = `ROWS_DEFAULT,     // Row drivers
    parameter int COLS     = `COLS_DEFAULT,     // Column drivers
    parameter int STEP_DIV = `STEP_DIV_DEFAULT  // hclk cycles per drive step
) (
    input  wire logic              hclk,            // Bus and core clock
    input  wire logic              hresetn,         // Async reset, active low
    input  wire logic              hsel,            // Slave select
    input  wire logic [7:0]        haddr,           // Byte address
    input  wire logic [1:0]        htrans,          // Transfer type
    input  wire logic              hwrite,          // Write access
    input  wire logic [2:0]        hsize,           // Transfer size
    input  wire logic [31:0]       hwdata,          // Write data
    input  wire logic              hready,          // Bus ready in
    output logic [31:0]            hrdata,          // Read data
    output logic                   hreadyout,       // Always ready
    output logic                   hresp,           // Always OKAY
    input  wire logic              colour_mode_pin, // Odd/even lookup split
    input  wire logic [COLS*6-1:0] pixel_data,      // Pixels of row_line
    output logic [6:0]             row_line,        // Display memory line wanted
    output logic [ROWS-1:0]        row_low,         // Row switched to ground rail
    output logic [COLS-1:0]        col_source,      // Column sources current
    output logic [COLS-1:0]        col_ground       // Column at low ground rail
);

    // ============================================================
    // Elaboration checks
    if (ROWS < 4 || ROWS > 128 || (ROWS % 2) != 0) begin : g_bad_rows
        $error("ROWS must be even and within 4..128");
    end
    if (COLS < 2 || (COLS % 2) != 0) begin : g_bad_cols
        $error("COLS must be even and at least 2");
    end
    if (STEP_DIV < 1 || STEP_DIV > 255) begin : g_bad_div
        $error("STEP_DIV must be within 1..255");
    end

    localparam logic [6:0] LAST_SINGLE = 7'(ROWS - 1);
    localparam logic [6:0] LAST_DUAL   = 7'(ROWS / 2 - 1);
    localparam logic [7:0] DRIVE_LAST  = 8'(`DRIVE_CYCLES - 1);
    localparam logic [7:0] SETUP_LAST  = 8'(`SETUP_CYCLES - 1);
    localparam logic [7:0] DIV_LAST    = 8'(STEP_DIV - 1);

    // ============================================================
    // Fixed 64-level pulse table
    function automatic logic [8:0] gray_lut(input logic [5:0] v);
        logic [8:0] w;
        w = {3'h0, v};
        if (w < `GRAY_SEG1) begin
            gray_lut = w;
        end else if (w < `GRAY_SEG2) begin
            gray_lut = `GRAY_BASE2 + 9'((w - `GRAY_SEG1) << 1);
        end else if (w < `GRAY_SEG3) begin
            gray_lut = `GRAY_BASE3 + 9'((w - `GRAY_SEG2) << 2);
        end else if (w < `GRAY_SEG4) begin
            gray_lut = `GRAY_BASE4 + 9'((w - `GRAY_SEG3) << 3);
        end else begin
            gray_lut = `GRAY_BASE5 + 9'((w - `GRAY_SEG4) << 4);
        end
    endfunction

    // ============================================================
    // Register file over AHB-Lite
    logic [5:0]  ctrl_r;
    logic [15:0] lut_r;
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic [31:0] rdata_r;
    logic [31:0] status;
    logic        addr_phase;

    oled_timing_pkg::row_state_type state_r;
    logic [7:0] phase_r;
    logic [6:0] row_idx_r;

    assign addr_phase = hsel && hready && htrans[1];
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = rdata_r;

    always_comb begin
        status = 32'h0000_0000;
        status[`STAT_ROW_LO +: 7]   = row_idx_r;
        status[`STAT_STATE_LO +: 2] = state_r;
        status[`STAT_PHASE_LO +: 8] = phase_r;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= addr_phase && hwrite;
            wr_addr_r <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= `CTRL_RESET;
            lut_r  <= `LUT_RESET;
        end else if (wr_pend_r) begin
            if (wr_addr_r == `REG_CTRL) begin
                ctrl_r <= hwdata[5:0];
            end else if (wr_addr_r == `REG_LUT) begin
                lut_r <= hwdata[15:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_r <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            unique case (haddr)
                `REG_CTRL:   rdata_r <= {26'h0, ctrl_r};
                `REG_LUT:    rdata_r <= {16'h0, lut_r};
                `REG_STATUS: rdata_r <= status;
                default:     rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    logic       enable;
    logic       mono;
    logic       reverse;
    logic       vflip;
    logic [7:0] odd_lut_entry_one;
    logic [7:0] even_lut_entry_one;
    oled_timing_pkg::scan_mode_type scan_mode_field;

    assign enable             = ctrl_r[`CTRL_ENABLE_BIT];
    assign mono               = ctrl_r[`CTRL_MONO_BIT];
    assign reverse            = ctrl_r[`CTRL_REVERSE_BIT];
    assign vflip              = ctrl_r[`CTRL_VFLIP_BIT];
    assign scan_mode_field    = oled_timing_pkg::scan_mode_type'(ctrl_r[`CTRL_SCAN_HI:`CTRL_SCAN_LO]);
    assign odd_lut_entry_one  = lut_r[`LUT_ODD_LO +: 8];
    assign even_lut_entry_one = lut_r[`LUT_EVEN_LO +: 8];

    // ============================================================
    // Drive step enable divider
    logic [7:0] div_r;
    logic       step_en;

    assign step_en = (div_r == DIV_LAST);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_r <= 8'h00;
        end else begin
            div_r <= step_en ? 8'h00 : div_r + 8'h01;
        end
    end

    // ============================================================
    // Row sequencer
    logic       scanning;
    logic       dual;
    logic [6:0] last_idx;
    logic [6:0] first_idx;
    logic [6:0] next_idx;

    assign scanning  = enable && scan_mode_field[1];
    assign dual      = (scan_mode_field == oled_timing_pkg::SCAN_DUAL);
    assign last_idx  = dual ? LAST_DUAL : LAST_SINGLE;
    assign first_idx = reverse ? last_idx : 7'h00;

    always_comb begin
        if (row_idx_r > last_idx) begin
            next_idx = first_idx;
        end else if (reverse) begin
            next_idx = (row_idx_r == 7'h00) ? last_idx : row_idx_r - 7'h01;
        end else begin
            next_idx = (row_idx_r == last_idx) ? 7'h00 : row_idx_r + 7'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r   <= oled_timing_pkg::ST_IDLE;
            phase_r   <= 8'h00;
            row_idx_r <= 7'h00;
        end else if (!scanning) begin
            state_r <= oled_timing_pkg::ST_IDLE;
            phase_r <= 8'h00;
        end else if (step_en) begin
            unique case (state_r)
                oled_timing_pkg::ST_IDLE: begin
                    state_r   <= oled_timing_pkg::ST_SETUP;
                    phase_r   <= 8'h00;
                    row_idx_r <= first_idx;
                end
                oled_timing_pkg::ST_SETUP: begin
                    if (phase_r == SETUP_LAST) begin
                        state_r <= oled_timing_pkg::ST_DRIVE;
                        phase_r <= 8'h00;
                    end else begin
                        phase_r <= phase_r + 8'h01;
                    end
                end
                oled_timing_pkg::ST_DRIVE: begin
                    if (phase_r == DRIVE_LAST) begin
                        state_r   <= oled_timing_pkg::ST_SETUP;
                        phase_r   <= 8'h00;
                        row_idx_r <= next_idx;
                    end else begin
                        phase_r <= phase_r + 8'h01;
                    end
                end
                default: begin
                    state_r <= oled_timing_pkg::ST_IDLE;
                    phase_r <= 8'h00;
                end
            endcase
        end
    end

    // Row pads and the memory line they show
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            row_low  <= '0;
            row_line <= 7'h00;
        end else begin
            row_low <= '0;
            if (state_r != oled_timing_pkg::ST_IDLE && row_idx_r <= last_idx) begin
                if (dual) begin
                    row_low[{row_idx_r[5:0], 1'b0}] <= 1'b1;
                    row_low[{row_idx_r[5:0], 1'b1}] <= 1'b1;
                end else begin
                    row_low[row_idx_r] <= 1'b1;
                end
            end
            row_line <= vflip ? last_idx - row_idx_r : row_idx_r;
        end
    end

    // ============================================================
    // Column pulse-width drive
    logic [COLS*6-1:0] pix_r;
    logic [8:0]        cnt [COLS];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pix_r <= '0;
        end else if (step_en && state_r == oled_timing_pkg::ST_SETUP && phase_r == SETUP_LAST) begin
            pix_r <= pixel_data;
        end
    end

    for (genvar i = 0; i < COLS; i++) begin : g_col
        logic [5:0] pv;
        logic [7:0] mono_byte;
        assign pv = pix_r[6*i +: 6];
        // Index 0 is the first, odd-numbered column
        assign mono_byte = (colour_mode_pin && (i % 2 == 1)) ? even_lut_entry_one
                                                             : odd_lut_entry_one;
        assign cnt[i] = mono ? (pv[0] ? {1'b0, mono_byte} : 9'h000)
                             : gray_lut(pv);
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                col_source[i] <= 1'b0;
                col_ground[i] <= 1'b1;
            end else begin
                col_source[i] <= (state_r == oled_timing_pkg::ST_DRIVE)
                                 && ({1'b0, phase_r} < cnt[i]);
                col_ground[i] <= !((state_r == oled_timing_pkg::ST_DRIVE)
                                 && ({1'b0, phase_r} < cnt[i]));
            end
        end
    end

    // ============================================================
    // Assertions
    logic in_drive;
    assign in_drive = (state_r == oled_timing_pkg::ST_DRIVE);

    a_gray_low_seg: assert property (@(posedge hclk) disable iff (!hresetn)
        (!mono && pix_r[5:0] == 6'h1F) |-> cnt[0] == 9'd46)
        else $error("gray value 31 must give 46 pulses");
    a_gray_high_seg: assert property (@(posedge hclk) disable iff (!hresetn)
        (!mono && pix_r[5:0] == 6'h3B) |-> cnt[0] == 9'd200)
        else $error("gray value 59 must give 200 pulses");
    a_gray_top_seg: assert property (@(posedge hclk) disable iff (!hresetn)
        (!mono && pix_r[5:0] == 6'h3F) |-> cnt[0] == 9'd256)
        else $error("gray value 63 must give 256 pulses");
    a_gray_shared: assert property (@(posedge hclk) disable iff (!hresetn)
        (!mono && pix_r[5:0] == pix_r[11:6]) |-> cnt[0] == cnt[1])
        else $error("odd and even columns differ in gray mode");
    a_mono_off: assert property (@(posedge hclk) disable iff (!hresetn)
        (mono && !pix_r[0]) |=> !col_source[0] || !$past(mono))
        else $error("off monochrome pixel sourced current");
    a_mono_odd_only: assert property (@(posedge hclk) disable iff (!hresetn)
        (mono && !colour_mode_pin && pix_r[6]) |-> cnt[1] == {1'b0, odd_lut_entry_one})
        else $error("even column ignored odd byte with pin low");
    a_col_elapsed: assert property (@(posedge hclk) disable iff (!hresetn)
        (in_drive && {1'b0, phase_r} >= cnt[0]) |=> !col_source[0] && col_ground[0])
        else $error("column sourced after its count elapsed");
    a_single_row: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(!dual) |-> $onehot0(row_low))
        else $error("more than one row selected in single scan");
    a_dual_pair: assert property (@(posedge hclk) disable iff (!hresetn)
        (in_drive && dual && row_idx_r <= LAST_DUAL) |=> $countones(row_low) == 2)
        else $error("dual scan did not select a row pair");
    a_row_ascend: assert property (@(posedge hclk) disable iff (!hresetn)
        (scanning && in_drive && step_en && phase_r == DRIVE_LAST && !reverse
         && row_idx_r < last_idx) |=> row_idx_r == $past(row_idx_r) + 7'h01)
        else $error("row did not advance upward");
    a_row_descend: assert property (@(posedge hclk) disable iff (!hresetn)
        (scanning && in_drive && step_en && phase_r == DRIVE_LAST && reverse
         && row_idx_r == 7'h00) |=> row_idx_r == $past(last_idx))
        else $error("reverse scan did not wrap to the last row");
    a_drive_length: assert property (@(posedge hclk) disable iff (!hresetn)
        (in_drive && step_en && phase_r == DRIVE_LAST && scanning)
        |=> state_r == oled_timing_pkg::ST_SETUP)
        else $error("drive period did not end after 256 steps");
    a_vflip_line: assert property (@(posedge hclk) disable iff (!hresetn)
        (vflip && !dual && state_r != oled_timing_pkg::ST_IDLE && $stable(ctrl_r))
        |=> row_line == LAST_SINGLE - $past(row_idx_r))
        else $error("vertical flip line mapping wrong");

    c_mono_row: cover property (@(posedge hclk) disable iff (!hresetn)
        in_drive && mono && col_source[0]);
    c_dual_wrap: cover property (@(posedge hclk) disable iff (!hresetn)
        in_drive && dual && row_idx_r == LAST_DUAL && phase_r == DRIVE_LAST);
    c_reverse_wrap: cover property (@(posedge hclk) disable iff (!hresetn)
        in_drive && reverse && row_idx_r == 7'h00 && phase_r == DRIVE_LAST);
    c_full_pulse: cover property (@(posedge hclk) disable iff (!hresetn)
        in_drive && phase_r == DRIVE_LAST && col_source[0]);

endmodule
`default_nettype wire

//--- oled_timing_cfg.svh
// Constants for the gray-scale pulse-width and row scan block
`ifndef OLED_TIMING_CFG_SVH
`define OLED_TIMING_CFG_SVH

// ============================================================
// Panel geometry and row timing
`define ROWS_DEFAULT      72
`define COLS_DEFAULT      256
`define DRIVE_CYCLES      256
`define SETUP_CYCLES      1
`define STEP_DIV_DEFAULT  1

// ============================================================
// Register byte offsets
`define REG_CTRL          8'h00
`define REG_LUT           8'h04
`define REG_STATUS        8'h08

// ============================================================
// Control register fields and reset value
`define CTRL_ENABLE_BIT   0
`define CTRL_MONO_BIT     1
`define CTRL_SCAN_LO      2
`define CTRL_SCAN_HI      3
`define CTRL_REVERSE_BIT  4
`define CTRL_VFLIP_BIT    5
`define CTRL_RESET        6'h00
`define LUT_RESET         16'h0000
`define LUT_ODD_LO        0
`define LUT_EVEN_LO       8

// ============================================================
// Status register fields
`define STAT_ROW_LO       0
`define STAT_STATE_LO     8
`define STAT_PHASE_LO     10

// ============================================================
// Fixed 64-level table segments
`define GRAY_SEG1         9'h010
`define GRAY_SEG2         9'h020
`define GRAY_SEG3         9'h030
`define GRAY_SEG4         9'h03C
`define GRAY_BASE2        9'h010
`define GRAY_BASE3        9'h030
`define GRAY_BASE4        9'h070
`define GRAY_BASE5        9'h0D0

`endif

//--- oled_timing_pkg.sv
// Types shared by the gray-scale pulse-width and row scan block
`default_nettype none
package oled_timing_pkg;
    typedef enum logic [1:0] {
        SCAN_OFF_A  = 2'b00,
        SCAN_OFF_B  = 2'b01,
        SCAN_SINGLE = 2'b10,
        SCAN_DUAL   = 2'b11
    } scan_mode_type;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SETUP = 2'b01,
        ST_DRIVE = 2'b10
    } row_state_type;
endpackage
`default_nettype wire

//--- oled_panel_model.sv
// Passive-matrix panel model: row pad levels and per-column pulse counts
`timescale 1ns/1ps
`default_nettype none
module oled_panel_model #(
    parameter int ROWS = 72,
    parameter int COLS = 4
) (
    input  wire logic [ROWS-1:0] row_low,    // Rows switched to ground
    input  wire logic            hclk,       // Clock
    input  wire logic            hresetn,    // Reset, active low
    input  wire logic [COLS-1:0] col_source, // Columns sourcing
    input  wire logic [COLS-1:0] col_ground, // Columns grounded
    output logic [ROWS-1:0]      row_level,  // Row pad level
    output logic [31:0]          ticks,      // Row periods begun
    output logic [COLS*9-1:0]    last_cnt,   // Pulses per column, last period
    output logic [31:0]          conflicts   // Cycles with bad column state
);
    logic [ROWS-1:0]   prev_rows_r;
    logic [COLS*9-1:0] cnt_r;

    // ============================================================
    // Released rows float to the pull-up
    assign row_level = ~row_low;

    // ============================================================
    // Period boundary on any change of the selected rows
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_rows_r <= '0;
            cnt_r       <= '0;
            ticks       <= 32'h0;
            last_cnt    <= '0;
            conflicts   <= 32'h0;
        end else begin
            prev_rows_r <= row_low;
            if (row_low !== prev_rows_r) begin
                ticks    <= ticks + 1;
                last_cnt <= cnt_r;
            end
            for (int i = 0; i < COLS; i++) begin
                cnt_r[9*i +: 9] <= ((row_low !== prev_rows_r) ? 9'h000 : cnt_r[9*i +: 9])
                                   + {8'h00, col_source[i]};
            end
            if ((col_source ^ col_ground) !== {COLS{1'b1}}) begin
                conflicts <= conflicts + 1;
            end
        end
    end
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the pulse-width and row scan block
`include "oled_timing_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int COLS = 4;
    localparam int ROWS = 72;
    logic              hclk = 1'b0;
    logic              hresetn = 1'b0;
    logic              hsel = 1'b0;
    logic [7:0]        haddr = 8'h00;
    logic [1:0]        htrans = 2'h0;
    logic              hwrite = 1'b0;
    logic [2:0]        hsize = 3'h2;
    logic [31:0]       hwdata = 32'h0;
    logic              colour_mode_pin = 1'b0;
    logic [COLS*6-1:0] pixel_data = '0;
    wire logic [31:0]  hrdata;
    wire logic         hreadyout;
    wire logic         hresp;
    wire logic [6:0]   row_line;
    wire logic [ROWS-1:0] row_low;
    wire logic [ROWS-1:0] row_level;
    wire logic [COLS-1:0] col_source;
    wire logic [COLS-1:0] col_ground;
    wire logic [31:0]  ticks;
    wire logic [COLS*9-1:0] last_cnt;
    wire logic [31:0]  conflicts;
    int                num_errors = 0;
    int                samples_checked = 0;
    int                cycles = 0;
    logic [31:0]       rd;

    always #50 hclk = ~hclk;

    oled_gray_pwm_row_scan #(.ROWS(ROWS), .COLS(COLS), .STEP_DIV(1)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .colour_mode_pin(colour_mode_pin), .pixel_data(pixel_data), .row_line(row_line),
        .row_low(row_low), .col_source(col_source), .col_ground(col_ground));

    oled_panel_model #(.ROWS(ROWS), .COLS(COLS)) panel (
        .hclk(hclk), .hresetn(hresetn), .row_low(row_low), .col_source(col_source),
        .col_ground(col_ground), .row_level(row_level), .ticks(ticks),
        .last_cnt(last_cnt), .conflicts(conflicts));

    // ============================================================
    // Checking and closing
    task automatic check(input logic [71:0] seen, input logic [71:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("Checked %0d values, %0d mismatches", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            num_errors++;
            stop_test();
        end
    end

    // ============================================================
    // Bus master, single word transfers
    task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= addr;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wdata;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdata = hrdata;
    endtask

    task automatic ahb_write(input logic [7:0] addr, input logic [31:0] data);
        bus(1'b1, addr, data, rd);
    endtask

    task automatic wait_tick;
        logic [31:0] t0;
        t0 = ticks;
        while (ticks === t0) @(posedge hclk);
    endtask

    function automatic int gray_exp(input int v);
        if (v < 16) return v;
        if (v < 32) return 16 + 2 * (v - 16);
        if (v < 48) return 48 + 4 * (v - 32);
        if (v < 60) return 112 + 8 * (v - 48);
        return 208 + 16 * (v - 60);
    endfunction

    // ============================================================
    // Scenarios
    task automatic test_regs;
        bus(1'b0, `REG_CTRL, 32'h0, rd);
        check(rd, `CTRL_RESET);
        bus(1'b0, `REG_LUT, 32'h0, rd);
        check(rd, `LUT_RESET);
        ahb_write(`REG_CTRL, 32'h0000003E);
        bus(1'b0, `REG_CTRL, 32'h0, rd);
        check(rd, 32'h0000003E);
        ahb_write(`REG_STATUS, 32'hFFFFFFFF);
        bus(1'b0, `REG_STATUS, 32'h0, rd);
        check(rd[9:8], oled_timing_pkg::ST_IDLE);
        check(row_low, 72'h0);
        check({col_ground, hreadyout, hresp}, {4'hF, 1'b1, 1'b0});
        ahb_write(`REG_LUT, 32'h0000A55A);
        bus(1'b0, `REG_LUT, 32'h0, rd);
        check(rd, 32'h0000A55A);
        bus(1'b0, 8'h0C, 32'h0, rd);
        check(rd, 32'h0);
        ahb_write(`REG_CTRL, 32'h0);
        $display("register test done");
    endtask

    task automatic test_gray;
        colour_mode_pin <= 1'b1;
        ahb_write(`REG_LUT, 32'h00000777);
        ahb_write(`REG_CTRL, 32'h00000009);
        for (int g = 0; g < 16; g++) begin
            for (int i = 0; i < COLS; i++) pixel_data[6*i +: 6] <= 6'(4 * g + 3 - i);
            wait_tick();
            wait_tick();
            for (int i = 0; i < COLS; i++) begin
                check(last_cnt[9*i +: 9], gray_exp(4 * g + 3 - i));
            end
        end
        $display("gray table test done");
    endtask

    task automatic test_mono;
        ahb_write(`REG_LUT, 32'h0000C825);
        pixel_data <= {6'h01, 6'h3E, 6'h3F, 6'h01};
        ahb_write(`REG_CTRL, 32'h0000000B);
        wait_tick();
        for (int p = 1; p >= 0; p--) begin
            colour_mode_pin <= p[0];
            wait_tick();
            wait_tick();
            for (int i = 0; i < COLS; i++) begin
                check(last_cnt[9*i +: 9], (i == 2) ? 0 : ((p == 1 && i % 2 == 1) ? 200 : 37));
            end
        end
        check(conflicts, 32'h0);
        $display("monochrome test done");
    endtask

    task automatic test_scan(input logic [5:0] ctrl, input int periods);
        int n;
        int idx;
        logic [ROWS-1:0] rows_exp;
        n = ctrl[2] ? 36 : 72;
        ahb_write(`REG_CTRL, 32'h0);
        repeat (5) @(posedge hclk);
        ahb_write(`REG_CTRL, {26'h0, ctrl});
        for (int k = 0; k < periods; k++) begin
            wait_tick();
            idx = ctrl[4] ? n - 1 - (k % n) : k % n;
            rows_exp = ctrl[2] ? (72'h3 << (2 * idx)) : (72'h1 << idx);
            check(row_low, rows_exp);
            check(row_level, ~rows_exp);
            check(row_line, ctrl[5] ? n - 1 - idx : idx);
        end
        $display("scan test %0h done", ctrl);
    endtask

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        test_regs();
        test_gray();
        test_mono();
        test_scan(6'h09, 73);
        test_scan(6'h39, 3);
        test_scan(6'h0D, 37);
        test_scan(6'h3D, 37);
        stop_test();
    end
endmodule
`default_nettype wire
